// file: dv/clock_mode_ctrl_assertions.sv
// Assertion checker for the clock mode controller outputs
`timescale 1ns/100ps
module clock_mode_ctrl_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_bvalid,
  input wire [1:0] mode_actual,
  input wire       loop_engaged,
  input wire [7:0] cmp_cycles,
  input wire [6:0] loop_prescale,
  input wire [4:0] loop_multiply,
  input wire [8:0] out_divisor,
  input wire       out_from_ext,
  input wire       fixed_freq_from_ext,
  input wire       fixed_freq_off
);
  // ==========================================================
  // Relations in the bus clock domain, off during reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_done; $rose(s_axi_bvalid); endsequence
  sequence mode_kept; $stable(mode_actual)[*2]; endsequence
  mode_delay_a: assert property (wr_done |=> mode_kept)
    else $error("mode moved right after a write");
  loop_flag_a: assert property (
    loop_engaged == mode_actual[0])
    else $error("loop engage mismatch");
  fixed_off_a: assert property (
    fixed_freq_off == !mode_actual[1])
    else $error("fixed clock gate mismatch");
  fixed_ext_a: assert property (
    fixed_freq_from_ext |-> mode_actual == 2'b11)
    else $error("fixed clock from ext outside loop mode");
  ext_src_a: assert property (
    out_from_ext == (mode_actual == 2'b10))
    else $error("output source mismatch");
  cmp_len_a: assert property (
    cmp_cycles == ((mode_actual != 2'b11) ? 8'h08 :
    (loop_prescale == 7'h40) ? 8'h02 : 8'h80))
    else $error("comparison length wrong");
  mul_step_a: assert property (
    !loop_multiply[0] && loop_multiply inside {[5'h04:5'h12]})
    else $error("multiply factor out of table");
  div_pow_a: assert property (
    mode_actual != 2'b11 |-> $onehot(out_divisor) && !out_divisor[8])
    else $error("divisor not a power of two");
endmodule // clock_mode_ctrl_chk
bind clock_mode_ctrl clock_mode_ctrl_chk u_chk (.aclk, .aresetn,
  .s_axi_bvalid, .mode_actual, .loop_engaged, .cmp_cycles,
  .loop_prescale, .loop_multiply, .out_divisor, .out_from_ext,
  .fixed_freq_from_ext, .fixed_freq_off);

// file: dv/ext_clock_source.sv
// Behavioural external clock source and its status levels
`timescale 1ns/100ps
module ext_clock_source #(
  parameter STARTUP = 6
) (
  input  wire aclk,
  input  wire osc_amp_enable,
  input  wire present,
  input  wire dco_ok,
  input  wire locked,
  input  wire drop_ref,
  input  wire drop_osc,
  output reg  ext_ref_ok_pin = 1'b0,
  output reg  osc_stable_pin = 1'b0,
  output reg  loop_lock_pin = 1'b0,
  output reg  ref_loss_pin = 1'b0,
  output reg  osc_loss_pin = 1'b0
);
  integer up_cnt = 0;
  // ==========================================================
  // Crystal runs only with the amplifier on, after start-up
  always @(posedge aclk)
  begin
    up_cnt         <= (osc_amp_enable && present) ? up_cnt + 1 : 0;
    ext_ref_ok_pin <= up_cnt >= STARTUP && !drop_ref;
    osc_stable_pin <= dco_ok && !drop_osc;
    loop_lock_pin  <= locked && !drop_osc && !drop_ref;
    ref_loss_pin   <= drop_ref;
    osc_loss_pin   <= drop_osc;
  end
endmodule // ext_clock_source

// file: dv/tb_clock_mode_ctrl.sv
// Self-checking bench for the clock mode controller
`timescale 1ns/100ps
module tb_clock_mode_ctrl;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ext_ref_ok_pin, osc_stable_pin, loop_lock_pin;
  logic        ref_loss_pin, osc_loss_pin, osc_amp_enable;
  logic        high_gain_enable, out_from_ext, loop_engaged;
  logic        loop_ref_external, fixed_freq_from_ext, fixed_freq_off;
  logic        present, dco_ok, locked, drop_ref, drop_osc;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode_actual, rsp;
  logic [3:0]  s_axi_wstrb, loop_ref_divisor;
  logic [4:0]  loop_multiply;
  logic [6:0]  loop_prescale;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cmp_cycles;
  logic [8:0]  out_divisor;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int          err_count = 0, tests_run = 0, cyc = 0;
  clock_mode_ctrl u_dut (.*);
  ext_clock_source #(.STARTUP(6)) u_src (.*);
  // ==========================================================
  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  // ==========================================================
  // Compare, bus and reset tasks
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  end
  endtask
  task rd_reg(input logic [7:0] a);
  begin
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  end
  endtask
  // Mode follows slowly, so poll it under a bound
  task wait_mode(input logic [1:0] m);
  begin
    repeat (40) if (mode_actual !== m) @(posedge aclk);
    chk("mode", m, mode_actual);
  end
  endtask
  task do_reset;
  begin
    {present, dco_ok, locked, drop_ref, drop_osc} <= 5'h00;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  end
  endtask
  // ==========================================================
  // Scenarios
  task t_write_once;
  begin
    do_reset();
    wr(8'h00, 8'h88);
    wr(8'h00, 8'h38);
    rd_reg(8'h00);
    chk("ctrl1", 32'h98, rd);
    chk("amp_en", 0, osc_amp_enable);
    chk("hg_en", 0, high_gain_enable);
    rd_reg(8'h10);
    chk("bad_rd", 32'h2, {rd[29:0], rsp});
    wr(8'h10, 8'h01);
    chk("bad_wr", 2'b10, rsp);
  end
  endtask
  task t_factors;
    int i;
  begin
    for (i = 0; i < 8; i++)
    begin
      wr(8'h04, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
      rd_reg(8'h0c);
      chk("n", 4 + 2 * i, rd[4:0]);
      chk("r", 1 << (7 - i), rd[15:8]);
      chk("p", 64, rd[22:16]);
      chk("out_div", 1 << (7 - i), out_divisor);
    end
  end
  endtask
  task t_loop_ext;
  begin
    do_reset();
    present <= 1'b1;
    wr(8'h00, 8'h38);
    repeat (12) @(posedge aclk);
    chk("scm_hold", 2'b00, mode_actual);
    dco_ok <= 1'b1;
    wait_mode(2'b11);
    chk("halved", 9'h002, out_divisor);
    chk("amp_on", 1, osc_amp_enable);
    locked <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("locked", 9'h001, out_divisor);
    chk("x_ext", 1, fixed_freq_from_ext);
    wr(8'h00, 8'hf8);
    rd_reg(8'h00);
    chk("hg_once", 32'h78, rd);
    chk("p_hi", 7'h01, loop_prescale);
    chk("x_edge", 1, fixed_freq_from_ext);
    wr(8'h04, 8'h01);
    repeat (4) @(posedge aclk);
    chk("x_bus", 0, fixed_freq_from_ext);
    drop_osc <= 1'b1;
    wait_mode(2'b10);
    drop_osc <= 1'b0;
    rd_reg(8'h00);
    chk("req_fbe", 32'h70, rd);
    wr(8'h00, 8'h78);
    repeat (12) @(posedge aclk);
    chk("fbe_hold", 2'b10, mode_actual);
    drop_ref <= 1'b1;
    wait_mode(2'b00);
  end
  endtask
  task t_internal;
  begin
    do_reset();
    {present, dco_ok} <= 2'b11;
    wr(8'h00, 8'ha8);
    wait_mode(2'b01);
    chk("int_ref", 0, loop_ref_external);
    chk("x_off", 1, fixed_freq_off);
    chk("hg_on", 1, high_gain_enable);
    chk("ref_div", 7, loop_ref_divisor);
    wr(8'h00, 8'h30);
    wait_mode(2'b10);
    chk("from_ext", 1, out_from_ext);
    chk("x_bus2", 0, {fixed_freq_off, fixed_freq_from_ext});
  end
  endtask
  task test_done;
  begin
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, aresetn} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {present, dco_ok, locked, drop_ref, drop_osc} = 5'h00;
    @(posedge aclk);
    t_write_once();
    t_factors();
    t_loop_ext();
    t_internal();
    test_done();
  end
endmodule // tb_clock_mode_ctrl

// file: hdl/clock_mode_ctrl.v
// Clock mode controller with AXI4-Lite register access
//
// Functional notes
// RQ1: Software writes two-bit requested mode; actual mode reported separately.
// RQ2: Actual mode follows the request when its minimum conditions hold.
// RQ3: Actual mode changes several cycles after a request write, never same.
// RQ4: Software sets ext-ref select and request upper bit on first write.
// RQ5: First write with ext-ref select 0 locks it; amplifier stays off.
// RQ6: Self-clocked with loop-external requested waits for stable and ref ok.
// RQ7: Bypass stays while loss flag and ref ok both set.
// RQ8: Loop-external needs ref ok and stable; compare 2 or 128 periods.
// RQ9: Self-clocked compares over 8 internal periods; reference not on output.
// RQ10: Loop-external halves output until first lock or after multiply change.
// RQ11: Self-clocked output osc/R; bypass output external/R.
// RQ12: Loop-internal output is internal ref/7 times 64 times N over R.
// RQ13: Loop-external output is ref times prescale times N over R.
// RQ14: Software keeps oscillator clock below its maximum frequency.
// RQ15: Multiply setting decodes to 4 through 18 in steps of two.
// RQ16: Divide setting decodes to powers of two, 1 up to 128.
// RQ17: Fixed clock equals bus clock outside special loop-external case.
// RQ18: Fixed clock is external ref/2 when ratio at least 4 and locked.
// RQ19: Fixed clock stopped in loop-internal and self-clocked modes.
// RQ20: High-gain select drives amplifier gain only with ext-ref select set.
// RQ21: High-gain select takes one write after reset only.
// RQ22: Reference loss goes self-clocked; oscillator loss goes bypass; update both.
// RQ23: Request passes a two-stage pipeline before the mode machine.
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module clock_mode_ctrl (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Analog side status levels, asynchronous
  input  wire        ext_ref_ok_pin,
  input  wire        osc_stable_pin,
  input  wire        loop_lock_pin,
  input  wire        ref_loss_pin,
  input  wire        osc_loss_pin,
  // Clock generator steering
  output reg  [1:0]  mode_actual,
  output reg         osc_amp_enable,
  output reg         high_gain_enable,
  output reg         out_from_ext,
  output reg         loop_engaged,
  output reg         loop_ref_external,
  output reg  [3:0]  loop_ref_divisor,
  output reg  [7:0]  cmp_cycles,
  output reg  [6:0]  loop_prescale,
  output reg  [4:0]  loop_multiply,
  output reg  [8:0]  out_divisor,
  output reg         fixed_freq_from_ext,
  output reg         fixed_freq_off
);

  // ========================================================================
  // One-hot mode states
  localparam [3:0] ST_SELF   = 4'b0001;
  localparam [3:0] ST_LOOP_I = 4'b0010;
  localparam [3:0] ST_BYPASS = 4'b0100;
  localparam [3:0] ST_LOOP_E = 4'b1000;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [1:0]  mode_request_r;
  reg  [1:0]  req_p1_r;
  reg  [1:0]  req_p2_r;
  reg         freq_range_r;
  reg         ext_ref_select_r;
  reg         ext_ref_locked_r;
  reg         first_wr_done_r;
  reg         high_gain_select_r;
  reg         high_gain_done_r;
  reg  [2:0]  multiply_select_r;
  reg  [2:0]  divide_select_r;
  reg         clock_loss_flag_r;
  reg         locked_once_r;
  reg  [7:0]  aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_have_r;

  wire [4:0]  pins_s;
  wire        ext_ref_ok;
  wire        osc_stable;
  wire        loop_lock;
  wire        ref_loss;
  wire        osc_loss;
  wire [4:0]  mul_factor;
  wire [7:0]  div_factor;
  wire [6:0]  prescale;
  wire        ratio_ok;
  wire        wr_fire;
  wire        wr_ctrl1;
  wire        wr_ctrl2;
  wire        wr_status;
  wire        wr_known;
  wire        hw_req_ld;
  wire [1:0]  hw_req_val;
  wire [1:0]  mode_nxt;

  // Mode code of a one-hot state
  function [1:0] mode_of;
    input [3:0] st;
    begin
      case (st)
        ST_LOOP_I: mode_of = `MODE_LOOP_INTERNAL;
        ST_BYPASS: mode_of = `MODE_BYPASS_EXT;
        ST_LOOP_E: mode_of = `MODE_LOOP_EXTERNAL;
        default:   mode_of = `MODE_SELF_CLOCKED;
      endcase
    end
  endfunction

  // Plain target of a request; self-clocked is the fallback
  function [3:0] target_of;
    input [1:0] req;
    input       ref_ok;
    input       stable;
    begin
      case (req)
        `MODE_LOOP_INTERNAL: target_of = stable ? ST_LOOP_I : ST_SELF;
        `MODE_BYPASS_EXT:    target_of = ref_ok ? ST_BYPASS : ST_SELF;
        `MODE_LOOP_EXTERNAL: target_of = (ref_ok && stable) ? ST_LOOP_E
                                                            : ST_SELF;
        default:             target_of = ST_SELF;
      endcase
    end
  endfunction

  // ========================================================================
  // Pin synchronisers and factor decode
  pin_sync #(
    .WIDTH    (5)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({osc_loss_pin, ref_loss_pin, loop_lock_pin,
                osc_stable_pin, ext_ref_ok_pin}),
    .sync_out (pins_s)
  );

  assign ext_ref_ok = pins_s[0];
  assign osc_stable = pins_s[1];
  assign loop_lock  = pins_s[2];
  assign ref_loss   = pins_s[3];
  assign osc_loss   = pins_s[4];

  factor_decode u_factor_decode (
    .mul_sel    (multiply_select_r),
    .div_sel    (divide_select_r),
    .freq_range (freq_range_r),
    .mul_factor (mul_factor),
    .div_factor (div_factor),
    .prescale   (prescale),
    .ratio_ok   (ratio_ok)
  );

  // ========================================================================
  // Write decode; a write completes once address and data are both held
  assign wr_fire   = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_ctrl1  = wr_fire && (aw_addr_r == `OFS_CTRL1) && w_strb_r[0];
  assign wr_ctrl2  = wr_fire && (aw_addr_r == `OFS_CTRL2) && w_strb_r[0];
  assign wr_status = wr_fire && (aw_addr_r == `OFS_STATUS) && w_strb_r[0];
  assign wr_known  = (aw_addr_r == `OFS_CTRL1) || (aw_addr_r == `OFS_CTRL2) ||
                     (aw_addr_r == `OFS_STATUS) ||
                     (aw_addr_r == `OFS_FACTOR);

  // ========================================================================
  // Mode state machine
  always @*
  begin
    state_nxt = target_of(req_p2_r, ext_ref_ok, osc_stable);   // RQ2
    case (state_r)
      ST_SELF:
      begin
        // Stays until both flags are up when loop-external is wanted
        if (req_p2_r == `MODE_LOOP_EXTERNAL && (!osc_stable || !ext_ref_ok))
          state_nxt = ST_SELF;                                  // RQ6
      end
      ST_LOOP_I:
      begin
        if (req_p2_r == `MODE_LOOP_EXTERNAL && !ext_ref_ok)
          state_nxt = ST_LOOP_I;
      end
      ST_BYPASS:
      begin
        if (ref_loss)
          state_nxt = ST_SELF;                                  // RQ22
        else if (req_p2_r == `MODE_LOOP_EXTERNAL && ext_ref_ok &&
                 (clock_loss_flag_r || !osc_stable))
          state_nxt = ST_BYPASS;                                // RQ7
      end
      ST_LOOP_E:
      begin
        if (ref_loss)
          state_nxt = ST_SELF;                                  // RQ22
        else if (req_p2_r == `MODE_LOOP_EXTERNAL &&
                 (osc_loss || !osc_stable) && ext_ref_ok)
          state_nxt = ST_BYPASS;                                // RQ22
        else if (req_p2_r == `MODE_LOOP_EXTERNAL && !ext_ref_ok)
          state_nxt = ST_SELF;                                  // RQ8
      end
      default:
        state_nxt = ST_SELF;
    endcase
  end

  assign mode_nxt = mode_of(state_nxt);

  // Loss events also rewrite the request so it matches the new mode
  assign hw_req_ld  = (state_r == ST_LOOP_E || state_r == ST_BYPASS) &&
                      (state_nxt == ST_SELF || state_nxt == ST_BYPASS) &&
                      (state_nxt != state_r) && (ref_loss || osc_loss);
  assign hw_req_val = mode_nxt;

  // ========================================================================
  // Mode state and request pipeline; pipeline gives the reporting lag
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r  <= ST_SELF;
      req_p1_r <= `RST_MODE_REQ;
      req_p2_r <= `RST_MODE_REQ;
    end
    else
    begin
      req_p1_r <= mode_request_r;                               // RQ23
      req_p2_r <= req_p1_r;                                     // RQ3
      state_r  <= state_nxt;
    end
  end

  // ========================================================================
  // Control registers with first-write and write-once behaviour
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_request_r     <= `RST_MODE_REQ;
      freq_range_r       <= `RST_FREQ_RANGE;
      ext_ref_select_r   <= `RST_EXT_REF_SEL;
      ext_ref_locked_r   <= 1'b0;
      first_wr_done_r    <= 1'b0;
      high_gain_select_r <= `RST_HIGH_GAIN;
      high_gain_done_r   <= 1'b0;
      multiply_select_r  <= `RST_MUL_SEL;
      divide_select_r    <= `RST_DIV_SEL;
    end
    else
    begin
      if (wr_ctrl1)
      begin
        first_wr_done_r <= 1'b1;
        freq_range_r    <= w_data_r[`C1_FREQ_RANGE];
        if (!ext_ref_locked_r)
          ext_ref_select_r <= w_data_r[`C1_EXT_REF_SEL];
        // A first write leaving the select low freezes it until reset
        if (!first_wr_done_r && !w_data_r[`C1_EXT_REF_SEL])
          ext_ref_locked_r <= 1'b1;                             // RQ5
        if (!high_gain_done_r)
        begin
          high_gain_select_r <= w_data_r[`C1_HIGH_GAIN];        // RQ21
          high_gain_done_r   <= 1'b1;
        end
      end
      // Hardware mode change wins over a software write in the same cycle
      if (hw_req_ld)
        mode_request_r <= hw_req_val;                           // RQ22
      else if (wr_ctrl1)
        mode_request_r <= w_data_r[`C1_REQ_HI:`C1_REQ_LO];      // RQ1
      if (wr_ctrl2)
      begin
        multiply_select_r <= w_data_r[`C2_MUL_HI:`C2_MUL_LO];
        divide_select_r   <= w_data_r[`C2_DIV_HI:`C2_DIV_LO];
      end
    end
  end

  // ========================================================================
  // Sticky loss flag, write one to clear; a new loss beats the clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      clock_loss_flag_r <= 1'b0;
    else if (ref_loss || osc_loss)
      clock_loss_flag_r <= 1'b1;
    else if (wr_status && w_data_r[`ST_LOSS_BIT])
      clock_loss_flag_r <= 1'b0;
  end

  // ========================================================================
  // First-lock tracking; halving lasts until lock after entry or relock
  always @(posedge aclk)
  begin
    if (!aresetn)
      locked_once_r <= 1'b0;
    else if (state_r != ST_LOOP_E || wr_ctrl2)
      locked_once_r <= 1'b0;                                    // RQ10
    else if (loop_lock)
      locked_once_r <= 1'b1;
  end

  // ========================================================================
  // Registered clock steering outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_actual         <= `MODE_SELF_CLOCKED;
      osc_amp_enable      <= 1'b0;
      high_gain_enable    <= 1'b0;
      out_from_ext        <= 1'b0;
      loop_engaged        <= 1'b0;
      loop_ref_external   <= 1'b0;
      loop_ref_divisor    <= `INT_REF_DIVISOR;
      cmp_cycles          <= `CMP_CYC_INT;
      loop_prescale       <= `PRESCALE_LOW;
      loop_multiply       <= `MUL_BASE;
      out_divisor         <= 9'h001;
      fixed_freq_from_ext <= 1'b0;
      fixed_freq_off      <= 1'b1;
    end
    else
    begin
      mode_actual      <= mode_of(state_r);                     // RQ1
      osc_amp_enable   <= ext_ref_select_r && mode_request_r[1];
      high_gain_enable <= high_gain_select_r && ext_ref_select_r; // RQ20
      // Bypass feeds the external clock straight to the divider
      out_from_ext     <= (state_r == ST_BYPASS);               // RQ11
      loop_engaged     <= (state_r == ST_LOOP_I) ||
                          (state_r == ST_LOOP_E);
      // Internal ref /7 always drives compares outside loop-external
      loop_ref_external <= (state_r == ST_LOOP_E);              // RQ9
      loop_ref_divisor  <= `INT_REF_DIVISOR;                    // RQ12
      if (state_r == ST_LOOP_E)
        cmp_cycles <= freq_range_r ? `CMP_CYC_EXT_HIGH
                                   : `CMP_CYC_EXT_LOW;          // RQ8
      else
        cmp_cycles <= `CMP_CYC_INT;                             // RQ9
      // Loop-internal prescale is fixed; loop-external follows the range
      loop_prescale <= (state_r == ST_LOOP_E) ? prescale
                                              : `PRESCALE_LOW;  // RQ13
      loop_multiply <= mul_factor;
      if (state_r == ST_LOOP_E && !locked_once_r)
        out_divisor <= {div_factor, 1'b0};                      // RQ10
      else
        out_divisor <= {1'b0, div_factor};                      // RQ11
      fixed_freq_from_ext <= (state_r == ST_LOOP_E) && ratio_ok && // RQ17
                             loop_lock;                         // RQ18
      fixed_freq_off <= (state_r == ST_LOOP_I) ||
                        (state_r == ST_SELF);                   // RQ19
    end
  end

  // ========================================================================
  // AXI write channels; each side taken independently, answered together
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ========================================================================
  // AXI read channel; one read at a time, data one cycle after address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_CTRL1:
            s_axi_rdata <= {24'h000000, high_gain_select_r, freq_range_r,
                            ext_ref_select_r, mode_request_r, 3'b000};
          `OFS_CTRL2:
            s_axi_rdata <= {24'h000000, 1'b0, multiply_select_r,
                            1'b0, divide_select_r};
          `OFS_STATUS:
            s_axi_rdata <= {24'h000000, high_gain_done_r, ext_ref_locked_r,
                            clock_loss_flag_r, loop_lock, ext_ref_ok,
                            osc_stable, mode_actual};
          `OFS_FACTOR:
            s_axi_rdata <= {9'h000, loop_prescale, div_factor,
                            3'b000, mul_factor};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // clock_mode_ctrl

// file: hdl/clock_mode_defines.vh
// Register map, field positions, reset values and decode constants
`ifndef CLOCK_MODE_DEFINES_VH
`define CLOCK_MODE_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL1        8'h00
`define OFS_CTRL2        8'h04
`define OFS_STATUS       8'h08
`define OFS_FACTOR       8'h0c

// ==========================================================================
// Field positions
`define C1_HIGH_GAIN     7
`define C1_FREQ_RANGE    6
`define C1_EXT_REF_SEL   5
`define C1_REQ_HI        4
`define C1_REQ_LO        3
`define C2_MUL_HI        6
`define C2_MUL_LO        4
`define C2_DIV_HI        2
`define C2_DIV_LO        0
`define ST_LOSS_BIT      5

// ==========================================================================
// Reset values
`define RST_MODE_REQ     2'b00
`define RST_FREQ_RANGE   1'b0
`define RST_EXT_REF_SEL  1'b0
`define RST_HIGH_GAIN    1'b0
`define RST_MUL_SEL      3'h0
`define RST_DIV_SEL      3'h0

// ==========================================================================
// Clock mode encodings
`define MODE_SELF_CLOCKED   2'b00
`define MODE_LOOP_INTERNAL  2'b01
`define MODE_BYPASS_EXT     2'b10
`define MODE_LOOP_EXTERNAL  2'b11

// ==========================================================================
// Loop constants
`define PRESCALE_LOW     7'h40
`define PRESCALE_HIGH    7'h01
`define INT_REF_DIVISOR  4'h7
`define CMP_CYC_INT      8'h08
`define CMP_CYC_EXT_LOW  8'h02
`define CMP_CYC_EXT_HIGH 8'h80
`define FIXED_RATIO_MIN  2'h2
`define MUL_BASE         5'h04

// ==========================================================================
// AXI responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// file: hdl/factor_decode.v
// Multiply, divide and prescale decode plus fixed clock ratio check
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module factor_decode (
  input  wire [2:0] mul_sel,
  input  wire [2:0] div_sel,
  input  wire       freq_range,
  output wire [4:0] mul_factor,
  output wire [7:0] div_factor,
  output wire [6:0] prescale,
  output wire       ratio_ok
);

  wire [11:0] pn;
  wire [11:0] four_r;

  // ========================================================================
  // Factor decodes
  assign mul_factor = {1'b0, mul_sel, 1'b0} + `MUL_BASE;      // RQ15
  assign div_factor = 8'h01 << div_sel;                       // RQ16
  assign prescale   = freq_range ? `PRESCALE_HIGH
                                 : `PRESCALE_LOW;            // RQ13

  // P*N/R >= 4 tested as P*N >= 4*R to avoid a divider
  assign pn       = {5'h00, prescale} * {7'h00, mul_factor};
  assign four_r   = {2'b00, div_factor, 2'b00};
  assign ratio_ok = (pn >= four_r);                           // RQ18

endmodule // factor_decode

// file: hdl/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter WIDTH = 5
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // ========================================================================
  // First stage feeds only the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync
